// ---- core/bas_pkg.sv ----
// Package for the breath alarm supervisor: constants, timing and carriers.
package bas_pkg;

  // Clock and time base.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned S_PER_MIN = 60;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int TICK_W = 17;
  localparam logic [TICK_W-1:0] TICK_LIM = TICK_W'(TICK_CYCLES - 1);

  // Supervision times, each in its own unit, then in milliseconds.
  localparam int unsigned WATCHDOG_MS = 500;
  localparam int unsigned NO_BREATH_S = 15;
  localparam int unsigned SILENCE_MIN = 2;
  localparam int unsigned TRIG_BLOCK_S = 5;
  localparam int unsigned FLASH_HZ = 2;
  localparam int unsigned NO_BREATH_MS = NO_BREATH_S * MS_PER_S;
  localparam int unsigned SILENCE_MS = SILENCE_MIN * S_PER_MIN * MS_PER_S;
  localparam int unsigned TRIG_BLOCK_MS = TRIG_BLOCK_S * MS_PER_S;
  localparam int unsigned FLASH_HALF_MS = MS_PER_S / (2 * FLASH_HZ);

  // Timer width covers the longest window in milliseconds.
  localparam int TMR_W = 17;
  localparam logic [TMR_W-1:0] WATCHDOG_LIM = TMR_W'(WATCHDOG_MS);
  localparam logic [TMR_W-1:0] NO_BREATH_LIM = TMR_W'(NO_BREATH_MS);
  localparam logic [TMR_W-1:0] SILENCE_LIM = TMR_W'(SILENCE_MS);
  localparam logic [TMR_W-1:0] TRIG_BLOCK_LIM = TMR_W'(TRIG_BLOCK_MS);
  localparam logic [TMR_W-1:0] FLASH_HALF_LIM = TMR_W'(FLASH_HALF_MS);

  // Register map.
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;
  localparam int CTRL_FLOOR21_BIT = 0;
  localparam logic CTRL_FLOOR21_RESET = 1'b0;
  localparam int STATUS_FLAGS_LSB = 0;

  // Comparator and pin inputs, all from outside the clock domain.
  typedef struct packed {
    logic o2_low_knob_ccw;
    logic o2_high_knob_cw;
    logic o2_below_lower;
    logic o2_above_upper;
    logic o2_below_18;
    logic o2_below_21;
    logic vol_low_knob_end;
    logic vol_high_knob_end;
    logic vol_above_upper;
    logic vol_below_lower;
    logic insp_flow_low;
    logic insp_press_low;
    logic inlet_valve_full_open_n;
    logic silence_button_n;
    logic silence_cancel;
    logic hand_bagging_mode;
    logic seq_clock;
    logic inhale_phase;
    logic exhale_phase;
    logic [3:0] supply_good;
    logic pressure_ceiling_alarm;
    logic exp_press_below_trig;
    logic exp_flow_high;
    logic exp_press_rising;
  } bas_sense_s;

  localparam bas_sense_s SENSE_IDLE = '{inlet_valve_full_open_n: 1'b1,
    silence_button_n: 1'b1, supply_good: 4'hf, default: '0};

  typedef struct packed {
    logic breath_request;
    logic supply_fail;
    logic no_breath_alarm_n;
    logic sequence_fault_n;
    logic silence_window_active;
    logic gas_supply_failure;
    logic exhaled_volume_out_of_range;
    logic o2_alarm;
    logic volume_limit_knobs_parked;
    logic oxygen_limit_knobs_parked_n;
  } bas_flags_s;

  localparam bas_flags_s FLAGS_RESET = '{no_breath_alarm_n: 1'b1,
    sequence_fault_n: 1'b1, oxygen_limit_knobs_parked_n: 1'b1,
    default: '0};

  typedef struct packed {
    logic trig;
    logic no_breath;
    logic gas_supply;
    logic exhaled_volume;
    logic vol_unset;
    logic o2_alarm;
    logic o2_unset;
  } bas_lamps_s;

endpackage

// ---- core/bas_sync.sv ----
// Two-flop synchroniser for a vector of asynchronous inputs.
module bas_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

// ---- core/bas_timer.sv ----
// Millisecond timeout timer with restart and clear.
module bas_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic restart,
  input wire logic clear,
  input wire logic [bas_pkg::TMR_W-1:0] limit,
  // Status
  output logic running_q,
  output logic expired_q
);

  logic [bas_pkg::TMR_W-1:0] count_q;
  logic reach;

  assign reach = running_q && tick && (count_q + 1'b1 >= limit);

  // A restart in the same cycle as a clear wins, so no press is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      running_q <= 1'b0;
      expired_q <= 1'b0;
    end else if (restart) begin
      count_q <= '0;
      running_q <= 1'b1;
      expired_q <= 1'b0;
    end else if (clear) begin
      count_q <= '0;
      running_q <= 1'b0;
      expired_q <= 1'b0;
    end else if (reach) begin
      count_q <= '0;
      running_q <= 1'b0;
      expired_q <= 1'b1;
    end else if (running_q && tick) begin
      count_q <= count_q + 1'b1;
    end
  end

endmodule

// ---- core/bas_supervisor.sv ----
// Alarm supervision core of the breathing machine, with an APB port.
//
// Notes on behaviour
// [R1] Oxygen knob-parked flag goes low when either oxygen knob is at its end.
// [R2] Oxygen alarm below lower, above upper, or below fixed floor 18 or 21.
// [R3] Volume knob-parked flag high when a volume knob is parked; lamp blinks.
// [R4] Exhaled volume out of range flags red flashing lamp and audible alarm.
// [R5] Gas loss: low flow, low pressure, valve fully open, not hand bagging.
// [R6] Gas loss flashes the gas supply lamp and requests the audible alarm.
// [R7] Each silence press starts or restarts a two-minute silence window.
// [R8] A cancel pulse during the silence window ends it at once.
// [R9] Silence mutes only volume, no-breath, gas supply and oxygen alarms.
// [R10] Pressure ceiling, sequencing and supply failure sound are never muted.
// [R11] Outside hand bagging, sequencing fault 0.5 s after last clock pulse.
// [R12] Sequencing fault whenever inhale and exhale phases overlap.
// [R13] No-breath alarm low after 15 s without inhale start or exhale start.
// [R14] No-breath alarm flashes its red lamp and requests the audible alarm.
// [R15] Sequencing fault or any failing supply-good input sounds the alarm.
// [R16] A 2 Hz flash rate pulses the lamps and the alarm tone.
// [R17] Each active alarm is ANDed with the flash rate onto its lamp.
// [R18] All alarms sound except the two knob-parked indications.
// [R19] Breath request and trigger lamp follow low expiratory pressure.
// [R20] Block request for 5 s after expiration start while exhaled flow is high.
// [R21] Block request while expiratory pressure rises during expiration.
// [R22] Every comparator input is synchronised before the alarm logic.
// [R23] Audible is OR of requests minus silenced mutables, gated by flash.
//
// Our own choices: register access over APB and the register offsets.
module bas_supervisor #(
  parameter logic [bas_pkg::TICK_W-1:0] P_TICK_LIM = bas_pkg::TICK_LIM,
  parameter logic [bas_pkg::TMR_W-1:0] P_WATCHDOG_LIM = bas_pkg::WATCHDOG_LIM,
  parameter logic [bas_pkg::TMR_W-1:0] P_NO_BREATH_LIM =
    bas_pkg::NO_BREATH_LIM,
  parameter logic [bas_pkg::TMR_W-1:0] P_SILENCE_LIM = bas_pkg::SILENCE_LIM,
  parameter logic [bas_pkg::TMR_W-1:0] P_TRIG_BLOCK_LIM =
    bas_pkg::TRIG_BLOCK_LIM,
  parameter logic [bas_pkg::TMR_W-1:0] P_FLASH_HALF_LIM =
    bas_pkg::FLASH_HALF_LIM
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bas_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparators, knobs and sequencing signals
  input wire bas_pkg::bas_sense_s sense,
  // Indications
  output bas_pkg::bas_flags_s flags_q,
  output bas_pkg::bas_lamps_s lamps_q,
  output logic audible_alarm_q
);

  bas_pkg::bas_sense_s sy;
  bas_pkg::bas_sense_s prev_q;
  bas_pkg::bas_flags_s flags_d;
  bas_pkg::bas_lamps_s lamps_d;
  logic audible_d;
  logic start_q;
  logic floor21_q;
  logic [bas_pkg::TICK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [bas_pkg::TMR_W-1:0] flash_cnt_q;
  logic flash_q;
  logic clock_rise, inhale_rise, exhale_rise;
  logic silence_press, silence_cancel_rise;
  logic wd_expired, nb_insp_expired, nb_exp_expired;
  logic sil_running, blk_running;
  logic flow_block, osc_block;
  logic mutable_req, fixed_req;
  logic setup, hit_ctrl, hit_status, wr_ok;

  // Comparators switch slowly, so a plain two-flop stage is enough.
  bas_sync #(
    .W($bits(bas_pkg::bas_sense_s)),
    .RST_VAL(bas_pkg::SENSE_IDLE)
  ) u_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(sense),
    .q(sy)
  ); // R22

  // Edge history and a one-cycle start pulse that arms the timeouts.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= bas_pkg::SENSE_IDLE;
      start_q <= 1'b1;
    end else begin
      prev_q <= sy;
      start_q <= 1'b0;
    end
  end

  assign clock_rise = sy.seq_clock && !prev_q.seq_clock;
  assign inhale_rise = sy.inhale_phase && !prev_q.inhale_phase;
  assign exhale_rise = sy.exhale_phase && !prev_q.exhale_phase;
  assign silence_press = !sy.silence_button_n && prev_q.silence_button_n;
  assign silence_cancel_rise = sy.silence_cancel && !prev_q.silence_cancel;

  // Millisecond tick shared by every timer.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= P_TICK_LIM) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Flash oscillator, toggled every half period.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (tick_q) begin
      if (flash_cnt_q + 1'b1 >= P_FLASH_HALF_LIM) begin
        flash_cnt_q <= '0;
        flash_q <= !flash_q; // R16
      end else begin
        flash_cnt_q <= flash_cnt_q + 1'b1;
      end
    end
  end

  // Clock watchdog, held clear while the patient is hand bagged.
  bas_timer u_watchdog (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .restart(clock_rise || start_q),
    .clear(sy.hand_bagging_mode),
    .limit(P_WATCHDOG_LIM),
    .running_q(),
    .expired_q(wd_expired)
  ); // R11

  bas_timer u_nb_insp (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .restart(inhale_rise || start_q),
    .clear(1'b0),
    .limit(P_NO_BREATH_LIM),
    .running_q(),
    .expired_q(nb_insp_expired)
  ); // R13

  bas_timer u_nb_exp (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .restart(exhale_rise || start_q),
    .clear(1'b0),
    .limit(P_NO_BREATH_LIM),
    .running_q(),
    .expired_q(nb_exp_expired)
  ); // R13

  // A press in the same cycle as a cancel keeps the window running.
  bas_timer u_silence (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .restart(silence_press), // R7
    .clear(silence_cancel_rise), // R8
    .limit(P_SILENCE_LIM),
    .running_q(sil_running),
    .expired_q()
  );

  bas_timer u_trig_block (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .restart(exhale_rise),
    .clear(inhale_rise),
    .limit(P_TRIG_BLOCK_LIM),
    .running_q(blk_running),
    .expired_q()
  ); // R20

  assign flow_block = sy.exhale_phase && blk_running &&
    sy.exp_flow_high; // R20
  assign osc_block = sy.exhale_phase && sy.exp_press_rising; // R21

  always_comb begin
    flags_d = bas_pkg::FLAGS_RESET;
    flags_d.oxygen_limit_knobs_parked_n =
      !(sy.o2_low_knob_ccw || sy.o2_high_knob_cw); // R1
    flags_d.volume_limit_knobs_parked =
      sy.vol_low_knob_end || sy.vol_high_knob_end; // R3
    flags_d.o2_alarm = sy.o2_below_lower || sy.o2_above_upper ||
      (floor21_q ? sy.o2_below_21 : sy.o2_below_18); // R2
    flags_d.exhaled_volume_out_of_range =
      sy.vol_above_upper || sy.vol_below_lower; // R4
    flags_d.gas_supply_failure = !sy.hand_bagging_mode &&
      sy.insp_flow_low && sy.insp_press_low &&
      !sy.inlet_valve_full_open_n; // R5
    flags_d.silence_window_active = sil_running; // R7
    flags_d.sequence_fault_n = !((wd_expired && !sy.hand_bagging_mode) ||
      (sy.inhale_phase && sy.exhale_phase)); // R11 R12
    flags_d.no_breath_alarm_n = !(nb_insp_expired || nb_exp_expired); // R13
    flags_d.supply_fail = (sy.supply_good != 4'hf); // R15
    flags_d.breath_request = sy.exp_press_below_trig &&
      !flow_block && !osc_block; // R19
  end

  // The oxygen knob lamp is steady; every other alarm lamp blinks.
  always_comb begin
    lamps_d.o2_unset = !flags_d.oxygen_limit_knobs_parked_n; // R1
    lamps_d.o2_alarm = flags_d.o2_alarm && flash_q; // R17
    lamps_d.vol_unset = flags_d.volume_limit_knobs_parked && flash_q; // R3
    lamps_d.exhaled_volume =
      flags_d.exhaled_volume_out_of_range && flash_q; // R4
    lamps_d.gas_supply = flags_d.gas_supply_failure && flash_q; // R6
    lamps_d.no_breath = !flags_d.no_breath_alarm_n && flash_q; // R14
    lamps_d.trig = flags_d.breath_request; // R19
  end

  // Knob-parked indications never reach the sounder.
  assign mutable_req = flags_d.exhaled_volume_out_of_range ||
    !flags_d.no_breath_alarm_n || flags_d.gas_supply_failure ||
    flags_d.o2_alarm; // R9 R14 R6 R18
  // Supply failures are never muted, so a new one always sounds.
  assign fixed_req = sy.pressure_ceiling_alarm ||
    !flags_d.sequence_fault_n || flags_d.supply_fail; // R10 R15
  assign audible_d = ((mutable_req && !sil_running) || fixed_req) &&
    flash_q; // R23 R16

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= bas_pkg::FLAGS_RESET;
      lamps_q <= '0;
      audible_alarm_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      lamps_q <= lamps_d;
      audible_alarm_q <= audible_d;
    end
  end

  // APB slave: data and response are prepared in the setup cycle, so
  // the access phase always completes in one cycle.
  assign setup = psel && !penable;
  assign hit_ctrl = (paddr == bas_pkg::CTRL_OFFSET);
  assign hit_status = (paddr == bas_pkg::STATUS_OFFSET);
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !(hit_ctrl || (hit_status && !pwrite));
        prdata <= '0;
        if (!pwrite && hit_ctrl) begin
          prdata[bas_pkg::CTRL_FLOOR21_BIT] <= floor21_q;
        end else if (!pwrite && hit_status) begin
          prdata[bas_pkg::STATUS_FLAGS_LSB +:
            $bits(bas_pkg::bas_flags_s)] <= flags_q;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      floor21_q <= bas_pkg::CTRL_FLOOR21_RESET;
    end else if (wr_ok && hit_ctrl) begin
      floor21_q <= pwdata[bas_pkg::CTRL_FLOOR21_BIT]; // R2
    end
  end

  oxy_parked_a: assert property (@(posedge ref_clk) // R1
    disable iff (!rst_n) 1'b1 |=> flags_q.oxygen_limit_knobs_parked_n ==
    !$past(sy.o2_low_knob_ccw || sy.o2_high_knob_cw))
    else $error("oxygen knob flag wrong");

  oxy_floor_a: assert property (@(posedge ref_clk) // R2
    disable iff (!rst_n) (floor21_q && sy.o2_below_21) |=> flags_q.o2_alarm)
    else $error("oxygen floor missed");

  gas_loss_a: assert property (@(posedge ref_clk) // R5
    disable iff (!rst_n) (!sy.hand_bagging_mode && sy.insp_flow_low &&
    sy.insp_press_low && !sy.inlet_valve_full_open_n) |=>
    flags_q.gas_supply_failure)
    else $error("gas loss not flagged");

  silence_start_a: assert property (@(posedge ref_clk) // R7
    disable iff (!rst_n)
    silence_press |=> sil_running ##1 flags_q.silence_window_active)
    else $error("silence window not started");

  silence_cancel_a: assert property (@(posedge ref_clk) // R8
    disable iff (!rst_n) (silence_cancel_rise && !silence_press) |=>
    !sil_running)
    else $error("silence window not cancelled");

  mute_scope_a: assert property (@(posedge ref_clk) // R9
    disable iff (!rst_n) (sil_running && !fixed_req) |=> !audible_alarm_q)
    else $error("silenced alarm sounded");

  never_muted_a: assert property (@(posedge ref_clk) // R10
    disable iff (!rst_n) (fixed_req && flash_q) |=> audible_alarm_q)
    else $error("unmutable alarm silent");

  phase_overlap_a: assert property (@(posedge ref_clk) // R12
    disable iff (!rst_n)
    (sy.inhale_phase && sy.exhale_phase) |=> !flags_q.sequence_fault_n)
    else $error("phase overlap not flagged");

  watchdog_fault_a: assert property (@(posedge ref_clk) // R11
    disable iff (!rst_n)
    (wd_expired && !sy.hand_bagging_mode) |=> !flags_q.sequence_fault_n)
    else $error("watchdog fault not flagged");

  lamp_flash_a: assert property (@(posedge ref_clk) // R17
    disable iff (!rst_n) !flash_q |=> !lamps_q.gas_supply &&
    !lamps_q.no_breath && !lamps_q.exhaled_volume && !lamps_q.vol_unset &&
    !lamps_q.o2_alarm && !audible_alarm_q)
    else $error("lamp lit outside flash");

  trig_block_a: assert property (@(posedge ref_clk) // R20
    disable iff (!rst_n)
    (flow_block || osc_block) |=> !flags_q.breath_request)
    else $error("blocked breath request raised");

  trig_pass_a: assert property (@(posedge ref_clk) // R19
    disable iff (!rst_n)
    (sy.exp_press_below_trig && !flow_block && !osc_block) |=>
    flags_q.breath_request && lamps_q.trig)
    else $error("breath request missed");

  silence_cover_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sil_running && mutable_req && !fixed_req);
  no_breath_cover_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(flags_q.no_breath_alarm_n));
  trig_cover_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sy.exp_press_below_trig && flow_block);

endmodule

// ---- verif/bas_panel_model.sv ----
// Model of the front panel, comparators and timing board signals.
module bas_panel_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic run,
  input wire logic overlap,
  input wire bas_pkg::bas_sense_s req,
  // Levels seen by the supervisor
  output bas_pkg::bas_sense_s sense
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic exhale_q;

  // A clock pulse starts every 12 cycles and swaps the phase; stopping run
  // freezes the phase, as a stalled timing board would.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      exhale_q <= 1'b0;
    end else if (run) begin
      cnt_q <= (cnt_q == 4'hb) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'hb) begin
        exhale_q <= ~exhale_q;
      end
    end
  end

  always_comb begin
    sense = req;
    sense.seq_clock = run && (cnt_q < 4'h2);
    sense.inhale_phase = overlap | ~exhale_q;
    sense.exhale_phase = overlap | exhale_q;
  end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the breath alarm supervisor.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run = 1'b1;
  logic overlap = 1'b0;
  bas_pkg::bas_sense_s req = bas_pkg::SENSE_IDLE;
  bas_pkg::bas_sense_s sense;
  bas_pkg::bas_sense_s s = bas_pkg::SENSE_IDLE;
  bas_pkg::bas_flags_s flags_q;
  bas_pkg::bas_flags_s prev;
  bas_pkg::bas_lamps_s lamps_q;
  bas_pkg::bas_lamps_s l_or;
  bas_pkg::bas_lamps_s l_and;
  logic audible_alarm_q;
  logic aud_hi;
  logic [31:0] seed = 32'h0000af9a;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_checks = 0;
  // Flag fields that follow the comparators with no timer involved.
  localparam bas_pkg::bas_flags_s PURE = '{supply_fail: 1'b1,
    gas_supply_failure: 1'b1, exhaled_volume_out_of_range: 1'b1,
    o2_alarm: 1'b1, volume_limit_knobs_parked: 1'b1,
    oxygen_limit_knobs_parked_n: 1'b1, default: 1'b0};

  always #4 ref_clk = ~ref_clk;

  // Short timers: 4 cycles a tick. The watchdog keeps its full 500 ticks,
  // so its expiry is checked at the true limit, some 2000 cycles.
  bas_supervisor #(.P_TICK_LIM(17'h3),
    .P_NO_BREATH_LIM(17'h14), .P_SILENCE_LIM(17'h1e),
    .P_TRIG_BLOCK_LIM(17'ha), .P_FLASH_HALF_LIM(17'h2)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense(sense), .flags_q(flags_q),
    .lamps_q(lamps_q), .audible_alarm_q(audible_alarm_q));

  bas_panel_model i_panel (.clk(ref_clk), .rst_n(rst_n), .run(run),
    .overlap(overlap), .req(req), .sense(sense));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic bas_pkg::bas_flags_s exp_flags(
    input bas_pkg::bas_sense_s v, input logic f21);
    bas_pkg::bas_flags_s e;
    e = '0;
    e.oxygen_limit_knobs_parked_n = ~(v.o2_low_knob_ccw | v.o2_high_knob_cw);
    e.o2_alarm = v.o2_below_lower | v.o2_above_upper |
      (f21 ? v.o2_below_21 : v.o2_below_18);
    e.volume_limit_knobs_parked = v.vol_low_knob_end | v.vol_high_knob_end;
    e.exhaled_volume_out_of_range = v.vol_above_upper | v.vol_below_lower;
    e.gas_supply_failure = ~v.hand_bagging_mode & v.insp_flow_low &
      v.insp_press_low & ~v.inlet_valve_full_open_n;
    e.supply_fail = (v.supply_good != 4'hf);
    return e;
  endfunction

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Samples the audible output and the lamps for n cycles.
  task automatic watch(input int n);
    aud_hi = 1'b0;
    l_or = '0;
    l_and = '1;
    repeat (n) begin
      @(negedge ref_clk);
      aud_hi = aud_hi | audible_alarm_q;
      l_or = l_or | lamps_q;
      l_and = l_and & lamps_q;
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    if (k >= 20) chk(1'b0, "apb no ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    step(8);
    chk(flags_q === bas_pkg::FLAGS_RESET && lamps_q === '0 &&
      audible_alarm_q === 1'b0 && pready === 1'b0, "reset values");
    rst_n <= 1'b1;
    step(10);
    apb(1'b0, bas_pkg::CTRL_OFFSET, 32'h0);
    chk(rd === 32'h0 && err === 1'b0, "ctrl reset value");
    for (int f = 0; f < 2; f++) begin
      apb(1'b1, bas_pkg::CTRL_OFFSET, 32'(f));
      apb(1'b0, bas_pkg::CTRL_OFFSET, 32'h0);
      chk(rd === 32'(f) && err === 1'b0, "ctrl readback");
      for (int i = 0; i < 20; i++) begin
        prev = exp_flags(s, f[0]);
        seed = xs(seed);
        s = seed[$bits(bas_pkg::bas_sense_s)-1:0];
        s.silence_button_n = 1'b1;
        s.silence_cancel = 1'b0;
        seed = xs(seed);
        s.supply_good = seed[3:0] | seed[7:4] | seed[11:8];
        @(posedge ref_clk);
        req <= s;
        repeat (2) @(negedge ref_clk);
        chk((flags_q & PURE) === (prev & PURE), "early flags");
        repeat (3) @(negedge ref_clk);
        chk((flags_q & PURE) === (exp_flags(s, f[0]) & PURE),
          "flags");
        chk(lamps_q.o2_unset === (s.o2_low_knob_ccw | s.o2_high_knob_cw),
          "steady lamp");
      end
    end
    apb(1'b0, bas_pkg::STATUS_OFFSET, 32'h0);
    chk((rd[9:0] & PURE) === (exp_flags(s, 1'b1) & PURE) &&
      rd[31:10] === '0 && err === 1'b0, "status read");
    apb(1'b1, bas_pkg::STATUS_OFFSET, 32'h0);
    chk(err === 1'b1, "status write taken");
    apb(1'b0, 12'h008, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read");
    $display("test registers and flags done");

    s = bas_pkg::SENSE_IDLE;
    s.o2_below_lower = 1'b1;
    s.vol_low_knob_end = 1'b1;
    s.vol_above_upper = 1'b1;
    s.insp_flow_low = 1'b1;
    s.insp_press_low = 1'b1;
    s.inlet_valve_full_open_n = 1'b0;
    @(posedge ref_clk);
    req <= s;
    step(6);
    watch(20);
    chk(aud_hi === 1'b1 && l_or.o2_alarm === 1'b1 &&
      l_and.o2_alarm === 1'b0, "o2 alarm flash");
    chk(l_or.vol_unset === 1'b1 && l_and.vol_unset === 1'b0 &&
      l_or.exhaled_volume === 1'b1 && l_and.exhaled_volume === 1'b0,
      "volume lamps");
    chk(l_or.gas_supply === 1'b1 && l_and.gas_supply === 1'b0,
      "gas lamp");
    req.silence_button_n <= 1'b0;
    step(3);
    req.silence_button_n <= 1'b1;
    step(6);
    chk(flags_q.silence_window_active === 1'b1, "no silence");
    watch(40);
    chk(aud_hi === 1'b0, "silence not muting");
    req.pressure_ceiling_alarm <= 1'b1;
    step(4);
    watch(20);
    chk(aud_hi === 1'b1, "ceiling muted");
    req.pressure_ceiling_alarm <= 1'b0;
    step(5);
    req.silence_cancel <= 1'b1;
    step(3);
    req.silence_cancel <= 1'b0;
    step(5);
    chk(flags_q.silence_window_active === 1'b0, "cancel ignored");
    watch(20);
    chk(aud_hi === 1'b1, "no sound after cancel");
    req.silence_button_n <= 1'b0;
    step(3);
    req.silence_button_n <= 1'b1;
    step(90);
    chk(flags_q.silence_window_active === 1'b1, "window short");
    step(50);
    chk(flags_q.silence_window_active === 1'b0, "window long");
    s = bas_pkg::SENSE_IDLE;
    s.o2_high_knob_cw = 1'b1;
    s.vol_low_knob_end = 1'b1;
    req <= s;
    step(6);
    watch(20);
    chk(aud_hi === 1'b0 && l_and.o2_unset === 1'b1 &&
      l_or.vol_unset === 1'b1, "knob alarm sounded");
    @(posedge ref_clk);
    req <= bas_pkg::SENSE_IDLE;
    $display("test silence done");

    do @(negedge ref_clk); while (sense.exhale_phase !== 1'b1);
    @(posedge ref_clk);
    run <= 1'b0;
    req.exp_press_below_trig <= 1'b1;
    req.exp_flow_high <= 1'b1;
    step(6);
    chk(flags_q.breath_request === 1'b0, "trigger not blocked");
    step(50);
    chk(flags_q.breath_request === 1'b1 && lamps_q.trig === 1'b1,
      "no trigger");
    req.exp_flow_high <= 1'b0;
    req.exp_press_rising <= 1'b1;
    step(6);
    chk(flags_q.breath_request === 1'b0, "rising not blocked");
    req.exp_press_rising <= 1'b0;
    step(1925);
    chk(flags_q.sequence_fault_n === 1'b1, "watchdog early");
    step(35);
    chk(flags_q.sequence_fault_n === 1'b0, "no watchdog fault");
    step(30);
    chk(flags_q.no_breath_alarm_n === 1'b0, "no breath alarm");
    watch(20);
    chk(aud_hi === 1'b1 && l_or.no_breath === 1'b1 &&
      l_and.no_breath === 1'b0, "no breath lamp");
    req.hand_bagging_mode <= 1'b1;
    step(6);
    chk(flags_q.sequence_fault_n === 1'b1, "fault in bagging");
    req.hand_bagging_mode <= 1'b0;
    run <= 1'b1;
    step(40);
    chk(flags_q.sequence_fault_n === 1'b1 &&
      flags_q.no_breath_alarm_n === 1'b1, "no recovery");
    overlap <= 1'b1;
    step(6);
    chk(flags_q.sequence_fault_n === 1'b0, "overlap missed");
    overlap <= 1'b0;
    $display("test sequencing and trigger done");
    report_and_stop();
  end
endmodule
